// [core/chrs_defines.svh]
// timing counts and encodings for the halt/reset sequencer
// assumes a single 250 MHz clock; no software-visible registers
`ifndef CHRS_DEFINES_SVH
`define CHRS_DEFINES_SVH
`define CHRS_RESET_MIN_PERIODS 3
`define CHRS_PC_RESET 16'h0000
`define CHRS_HALT_OPCODE 8'h76
`endif

// [core/chrs_pkg.sv]
// types for the halt/reset sequencer
// assumes chrs_defines.svh supplies the constants
package chrs_pkg;
	typedef enum logic [2:0] {
		CHRS_FIRST,
		CHRS_SECOND,
		CHRS_THIRD,
		CHRS_HALT_WAIT,
		CHRS_HOLD
	} chrs_state_t;
	// bus-side status of one state
	typedef struct packed {
		logic        transfer;
		logic        interrupt_ack_status;
		logic [15:0] addr;
	} chrs_bus_t;
endpackage : chrs_pkg

// [core/chrs_sequencer.sv]
// halt, hold, interrupt and reset sequencing of the processor control path
// assumes inputs synchronous to i_clk; one i_clk edge stands for one phase-one edge
`timescale 1ns/1ns
`include "chrs_defines.svh"
module chrs_sequencer #(
	parameter int PC_W = 16
) (
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	input  wire logic                i_clk_en,
	// processor reset pin, active high
	input  wire logic                i_cpu_reset,
	// requests from outside
	input  wire logic                i_hold_req,
	input  wire logic                i_int_req,
	// instruction decode
	input  wire logic                i_last_state,
	input  wire logic [7:0]          i_opcode,
	input  wire logic                i_enable_interrupts_opcode,
	input  wire logic                i_disable_interrupts_opcode,
	// bus and status
	output logic                     o_transfer,
	output logic                     o_interrupt_ack_status,
	output logic [PC_W-1:0]          o_addr,
	output logic                     o_bus_hold_acknowledge,
	output logic                     o_halted,
	output logic                     o_interrupt_enable_flag,
	output chrs_pkg::chrs_state_t    o_state
);
	chrs_pkg::chrs_state_t state;
	logic [PC_W-1:0]       pc;
	logic                  halt_pending;
	logic                  int_latch;
	logic                  int_cycle;
	logic                  int_wake;
	logic                  decode_live;
	logic                  latch_point;
	logic                  pc_step;

	// ----------------------------------------
	// shared conditions
	// ----------------------------------------
	// an interrupt can only wake the halt while the enable flag is up
	assign int_wake    = i_int_req && o_interrupt_enable_flag;

	// no instruction runs in halt wait or hold, so decode strobes are ignored there;
	// a stray enable strobe while parked would otherwise unmask a halt entered masked
	assign decode_live = (state != chrs_pkg::CHRS_HALT_WAIT)
		&& (state != chrs_pkg::CHRS_HOLD);

	// interrupts are taken at an instruction boundary or while parked in halt wait
	assign latch_point = i_last_state || (state == chrs_pkg::CHRS_HALT_WAIT);

	// one count per ordinary machine cycle; halt entry and interrupt cycles hold it
	assign pc_step     = (state == chrs_pkg::CHRS_SECOND) && !halt_pending && !int_cycle
		&& !int_latch;

	// ----------------------------------------
	// state sequencing
	// ----------------------------------------
	// reset pin wins over every condition, halted or not, but only on edges where i_clk_en is high
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= chrs_pkg::CHRS_FIRST;
		end else if (i_clk_en) begin
			if (i_cpu_reset) begin
				state <= chrs_pkg::CHRS_FIRST;
			end else begin
				unique case (state)
					chrs_pkg::CHRS_FIRST: begin
						state <= chrs_pkg::CHRS_SECOND;
					end
					chrs_pkg::CHRS_SECOND: begin
						// halt entered after second bus state of next cycle
						if (halt_pending) begin
							state <= chrs_pkg::CHRS_HALT_WAIT;
						end else begin
							state <= chrs_pkg::CHRS_THIRD;
						end
					end
					chrs_pkg::CHRS_THIRD: begin
						state <= chrs_pkg::CHRS_FIRST;
					end
					chrs_pkg::CHRS_HALT_WAIT: begin
						// checked every cycle; only hold, an enabled interrupt or the reset pin leave
						if (i_hold_req) begin
							state <= chrs_pkg::CHRS_HOLD;
						end else if (int_wake) begin
							state <= chrs_pkg::CHRS_FIRST;
						end
					end
					chrs_pkg::CHRS_HOLD: begin
						if (!i_hold_req) begin
							state <= chrs_pkg::CHRS_HALT_WAIT;
						end
					end
					// three codes of the state vector are unused; recover to a fresh cycle
					default: begin
						state <= chrs_pkg::CHRS_FIRST;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// halt request, set by the halt opcode
	// ----------------------------------------
	// cleared on reaching halt wait, so the cycle after an interrupt wake does not park a second time
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			halt_pending <= 1'b0;
		end else if (i_clk_en) begin
			if (i_cpu_reset || state == chrs_pkg::CHRS_HALT_WAIT) begin
				halt_pending <= 1'b0;
			end else if (decode_live && i_last_state && i_opcode == `CHRS_HALT_OPCODE) begin
				halt_pending <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// interrupt enable flag and latch
	// ----------------------------------------
	// flag value when halt is entered decides whether interrupts can wake
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_interrupt_enable_flag <= 1'b0;
		end else if (i_clk_en) begin
			if (i_cpu_reset) begin
				o_interrupt_enable_flag <= 1'b0;
			end else if (int_latch && state == chrs_pkg::CHRS_THIRD) begin
				o_interrupt_enable_flag <= 1'b0; // accepted interrupt disables further ones
			end else if (decode_live && i_enable_interrupts_opcode && i_last_state) begin
				o_interrupt_enable_flag <= 1'b1;
			end else if (decode_live && i_disable_interrupts_opcode && i_last_state) begin
				o_interrupt_enable_flag <= 1'b0;
			end
		end
	end

	// latch at the instruction's last state so it completes first, or while parked in halt wait
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			int_latch <= 1'b0;
		end else if (i_clk_en) begin
			if (i_cpu_reset) begin
				int_latch <= 1'b0;
			end else if (int_wake && latch_point) begin
				int_latch <= 1'b1;
			end else if (int_cycle && state == chrs_pkg::CHRS_THIRD) begin
				int_latch <= 1'b0;
			end
		end
	end

	// interrupt machine cycle runs from first bus state while latched
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			int_cycle <= 1'b0;
		end else if (i_clk_en) begin
			if (i_cpu_reset || state == chrs_pkg::CHRS_THIRD) begin
				int_cycle <= 1'b0;
			end else if (int_latch && state == chrs_pkg::CHRS_FIRST) begin
				int_cycle <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// program counter
	// ----------------------------------------
	// the pc and the interrupt enable flag reset; other flags and working registers live elsewhere and are untouched
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pc <= PC_W'(`CHRS_PC_RESET);
		end else if (i_clk_en) begin
			if (i_cpu_reset) begin
				pc <= PC_W'(`CHRS_PC_RESET);
			end else if (pc_step) begin
				pc <= pc + PC_W'(1);
			end
		end
	end

	// ----------------------------------------
	// bus outputs
	// ----------------------------------------
	// transfer strobe drops in halt wait, hold and reset; it lags the state by one edge
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_transfer <= 1'b0;
		end else if (i_clk_en) begin
			o_transfer <= !i_cpu_reset && decode_live;
		end
	end

	// acknowledge status flags the first bus state of the interrupt cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_interrupt_ack_status <= 1'b0;
		end else if (i_clk_en) begin
			o_interrupt_ack_status <= int_latch && state == chrs_pkg::CHRS_FIRST;
		end
	end

	// address is a registered copy of the counter, so it trails pc by one edge
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_addr <= '0;
		end else if (i_clk_en) begin
			o_addr <= pc;
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	// status decodes are combinational and follow the state with no lag;
	// o_state exposes the raw enum for the checker
	assign o_bus_hold_acknowledge = (state == chrs_pkg::CHRS_HOLD);
	assign o_halted               = (state == chrs_pkg::CHRS_HALT_WAIT);
	assign o_state                = state;
endmodule : chrs_sequencer

// [tb/chrs_partner.sv]
// reset, bus-hold and interrupt logic outside the processor
// tasks are called by the bench just after a clock edge
`timescale 1ns/1ns
module chrs_partner (
	// clock
	input  wire logic i_clk,
	// requests to the processor
	output logic      o_cpu_reset,
	output logic      o_hold_req,
	output logic      o_int_req
);
	// power-up always starts inside reset, registers are unknown
	initial begin
		o_cpu_reset = 1'b1;
		o_hold_req  = 1'b0;
		o_int_req   = 1'b0;
	end
	// never shorter than three periods, or the counter may not clear
	task automatic pulse(input int n);
		o_cpu_reset = 1'b1;
		repeat ((n < 3) ? 3 : n) @(posedge i_clk);
		#1 o_cpu_reset = 1'b0;
	endtask : pulse
	task automatic req(input logic h, input logic q);
		o_hold_req = h;
		o_int_req  = q;
	endtask : req
endmodule : chrs_partner

// [tb/chrs_sva.sv]
// concurrent checks on the halt/reset sequencer ports
// bound into chrs_sequencer from the bench top file
`timescale 1ns/1ns
module chrs_sva #(
	parameter int PC_W = 16
) (
	// clock, reset and requests
	input wire logic                  i_clk,
	input wire logic                  i_reset_n,
	input wire logic                  i_clk_en,
	input wire logic                  i_cpu_reset,
	input wire logic                  i_hold_req,
	input wire logic                  i_int_req,
	// status
	input wire logic                  o_transfer,
	input wire logic                  o_interrupt_ack_status,
	input wire logic [PC_W-1:0]       o_addr,
	input wire logic                  o_bus_hold_acknowledge,
	input wire logic                  o_halted,
	input wire logic                  o_interrupt_enable_flag,
	input wire chrs_pkg::chrs_state_t o_state
);
	// ----
	// checks
	// ----
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	rst_first_a: assert property (i_cpu_reset && i_clk_en |=>
		o_state == chrs_pkg::CHRS_FIRST) else $error("reset missed first state");
	rst_pc_a: assert property (i_cpu_reset && i_clk_en ##1 i_clk_en |=>
		o_addr == {PC_W{1'b0}}) else $error("reset left address nonzero");
	hold_enter_a: assert property (o_halted && i_hold_req && i_clk_en && !i_cpu_reset
		|=> o_bus_hold_acknowledge) else $error("hold not taken while halted");
	hold_exit_a: assert property (o_halted ##1 (o_bus_hold_acknowledge && !i_hold_req
		&& i_clk_en && !i_cpu_reset) |=> o_halted) else $error("hold exit missed halt");
	int_exit_a: assert property (o_halted && i_int_req && o_interrupt_enable_flag
		&& !i_hold_req && i_clk_en && !i_cpu_reset |=> o_state == chrs_pkg::CHRS_FIRST)
		else $error("enabled interrupt kept halt");
	halt_stay_a: assert property (o_halted && !i_cpu_reset && !i_hold_req
		&& !(i_int_req && o_interrupt_enable_flag) |=> o_halted) else $error("halt left");
	halt_entry_a: assert property ($rose(o_halted) |->
		$past(o_state) == chrs_pkg::CHRS_SECOND || $past(o_bus_hold_acknowledge))
		else $error("halt entered from wrong state");
	no_xfer_a: assert property (o_halted && i_clk_en |=> !o_transfer)
		else $error("transfer while halted");
	cover property (o_bus_hold_acknowledge);
	cover property ($rose(o_halted));
	cover property (o_interrupt_ack_status);
endmodule : chrs_sva

// [tb/tb_cpu_halt_reset_sequencer.sv]
// self-checking bench for the halt/reset sequencer
// assumes chrs_partner drives reset, hold and interrupt
`timescale 1ns/1ns
`include "chrs_defines.svh"
module tb_cpu_halt_reset_sequencer;
	logic                  i_clk, i_reset_n, i_clk_en, i_cpu_reset, i_hold_req, i_int_req;
	logic                  i_last_state, i_enable_interrupts_opcode, i_disable_interrupts_opcode;
	logic [7:0]            i_opcode;
	logic                  o_transfer, o_interrupt_ack_status, o_bus_hold_acknowledge;
	logic                  o_halted, o_interrupt_enable_flag;
	logic [15:0]           o_addr;
	chrs_pkg::chrs_state_t o_state;
	int                    error_cnt = 0;
	int                    samples_checked = 0;
	chrs_sequencer chrs_sequencer_i (.i_clk, .i_reset_n, .i_clk_en, .i_cpu_reset, .i_hold_req,
		.i_int_req, .i_last_state, .i_opcode, .i_enable_interrupts_opcode,
		.i_disable_interrupts_opcode, .o_transfer, .o_interrupt_ack_status, .o_addr,
		.o_bus_hold_acknowledge, .o_halted, .o_interrupt_enable_flag, .o_state);
	chrs_partner chrs_partner_i (.i_clk, .o_cpu_reset(i_cpu_reset), .o_hold_req(i_hold_req),
		.o_int_req(i_int_req));
	// ----
	// shared tasks
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic results;
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	// one decode strobe in the last state, then idle
	task automatic op(input logic [7:0] o, input logic e, input logic d);
		{i_last_state, i_opcode} = {1'b1, o};
		{i_enable_interrupts_opcode, i_disable_interrupts_opcode} = {e, d};
		tick(1);
		{i_last_state, i_opcode} = 9'h000;
		{i_enable_interrupts_opcode, i_disable_interrupts_opcode} = 2'h0;
	endtask : op
	task automatic halt_up;
		op(`CHRS_HALT_OPCODE, 1'b0, 1'b0);
		for (int k = 0; k < 12 && o_halted !== 1'b1; k++)
			tick(1);
		check("halt_entry", 16'h0001, {15'h0000, o_halted});
		if (o_halted !== 1'b1)
			results();
	endtask : halt_up
	// ----
	// scenarios
	// ----
	task automatic s_reset;
		chrs_partner_i.pulse(3);
		check("reset_state", {13'h0000, chrs_pkg::CHRS_FIRST}, {13'h0000, o_state});
		check("start_addr", `CHRS_PC_RESET, o_addr);
		check("reset_xfer", 16'h0000, {15'h0000, o_transfer});
	endtask : s_reset
	// hold wins over a pending interrupt, then the interrupt releases
	task automatic s_hold_int;
		op(8'h00, 1'b1, 1'b0);
		check("flag_set", 16'h0001, {15'h0000, o_interrupt_enable_flag});
		check("running_xfer", 16'h0001, {15'h0000, o_transfer});
		halt_up();
		chrs_partner_i.req(1'b1, 1'b1);
		tick(1);
		check("hold_ack", 16'h0001, {15'h0000, o_bus_hold_acknowledge});
		chrs_partner_i.req(1'b0, 1'b1);
		tick(1);
		check("hold_exit", 16'h0001, {15'h0000, o_halted});
		tick(1);
		check("int_exit", {13'h0000, chrs_pkg::CHRS_FIRST}, {13'h0000, o_state});
		chrs_partner_i.req(1'b0, 1'b0);
		tick(1);
		check("int_ack", 16'h0001, {15'h0000, o_interrupt_ack_status});
		tick(2);
		check("int_addr", 16'h0001, o_addr);
		check("int_flag_clr", 16'h0000, {15'h0000, o_interrupt_enable_flag});
	endtask : s_hold_int
	// masked interrupt, a frozen clock enable, then reset frees the halt
	task automatic s_masked;
		op(8'h00, 1'b1, 1'b0);
		op(8'h00, 1'b0, 1'b1);
		check("flag_masked", 16'h0000, {15'h0000, o_interrupt_enable_flag});
		halt_up();
		chrs_partner_i.req(1'b1, 1'b1);
		i_clk_en = 1'b0;
		tick(2);
		check("frozen_halt", 16'h0001, {15'h0000, o_halted});
		check("frozen_hold", 16'h0000, {15'h0000, o_bus_hold_acknowledge});
		chrs_partner_i.req(1'b0, 1'b1);
		i_clk_en = 1'b1;
		tick(8);
		check("masked_int", 16'h0001, {15'h0000, o_halted});
		check("no_transfer", 16'h0000, {15'h0000, o_transfer});
		chrs_partner_i.pulse(4);
		check("reset_halt", {13'h0000, chrs_pkg::CHRS_FIRST}, {13'h0000, o_state});
		chrs_partner_i.req(1'b0, 1'b0);
	endtask : s_masked
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		{i_reset_n, i_clk_en, i_last_state, i_opcode} = 11'h200; // in reset, clock enabled
		{i_enable_interrupts_opcode, i_disable_interrupts_opcode} = 2'h0;
		repeat (20) @(posedge i_clk);
		#1 i_reset_n = 1'b1;
		s_reset();
		s_hold_int();
		s_masked();
		results();
	end
endmodule : tb_cpu_halt_reset_sequencer
bind chrs_sequencer chrs_sva #(.PC_W(PC_W)) chrs_sva_i (.i_clk, .i_reset_n, .i_clk_en,
	.i_cpu_reset, .i_hold_req, .i_int_req, .o_transfer, .o_interrupt_ack_status, .o_addr,
	.o_bus_hold_acknowledge, .o_halted, .o_interrupt_enable_flag, .o_state);
